// File: hdl/smc_cfg.svh
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH

// Register byte address
`define SMC_ADDR_MISC       12'h00C

// Field positions in the control register
`define SMC_BIT_POR         7
`define SMC_BIT_RISE        6
`define SMC_BIT_FALL        5
`define SMC_BIT_EXT_EN      4
`define SMC_BIT_PWM_A       3
`define SMC_BIT_PWM_B       2
`define SMC_BIT_SLOW        1
`define SMC_BIT_WATCHDOG_ARM        0

// Reset values of the control fields
`define SMC_RST_RISE        1'b0
`define SMC_RST_FALL        1'b0
`define SMC_RST_EXT_EN      1'b1
`define SMC_RST_SLOW        1'b0

// Modulator periods and tick ratios
`define SMC_PWM_FAST_PER    13'h0100
`define SMC_PWM_SLOW_PER    13'h1000
`define SMC_PWM_FAST_MUL    9'h100
`define SMC_PWM_SLOW_MUL    9'h010

// Bus divide ratios in oscillator clocks
`define SMC_DIV_NORMAL      6'h02
`define SMC_DIV_SLOW        6'h20

`endif

// File: hdl/smc_pkg.sv
package smc_pkg;

    typedef enum logic [1:0] {
        SMC_SENSE_FALL_LOW = 2'b00,
        SMC_SENSE_FALL     = 2'b01,
        SMC_SENSE_RISE     = 2'b10,
        SMC_SENSE_BOTH     = 2'b11
    } smc_sense_e;

    typedef enum logic [2:0] {
        SMC_APB_IDLE   = 3'b001,
        SMC_APB_SETUP  = 3'b010,
        SMC_APB_ACCESS = 3'b100
    } smc_apb_e;

endpackage

// File: hdl/smc_edge_if.sv
`timescale 1ns/1ps

interface smc_edge_if;
    logic                  sample;
    smc_pkg::smc_sense_e   sense;
    logic                  request;

    modport detector (
        input  sample,
        input  sense,
        output request
    );
    modport owner (
        output sample,
        output sense,
        input  request
    );
endinterface

// File: hdl/smc_edge_detect.sv
`timescale 1ns/1ps

// Edge and level detector for one already synchronised line
module smc_edge_detect (
    input  wire logic   pclk,
    input  wire logic   presetn,
    smc_edge_if.detector port_i
);
    logic prev_reg;
    logic prev_next;
    logic fell;
    logic rose;

    always_comb begin
        prev_next = port_i.sample;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b1;
        end else begin
            prev_reg <= prev_next;
        end
    end

    // Edges come from comparing consecutive bus-clock samples
    assign fell = prev_reg & ~port_i.sample; // RL20
    assign rose = ~prev_reg & port_i.sample; // RL20

    always_comb begin
        case (port_i.sense)
            smc_pkg::SMC_SENSE_FALL_LOW: port_i.request = fell | ~port_i.sample; // RL20
            smc_pkg::SMC_SENSE_FALL:     port_i.request = fell;
            smc_pkg::SMC_SENSE_RISE:     port_i.request = rose;
            smc_pkg::SMC_SENSE_BOTH:     port_i.request = fell | rose;
            default:                     port_i.request = 1'b0;
        endcase
    end

    a_level_holds: assert property (@(posedge pclk) disable iff (!presetn) // RL20
        (port_i.sense == smc_pkg::SMC_SENSE_FALL_LOW && !port_i.sample)
        |-> port_i.request)
        else $error("Low level did not hold the request");

    a_edge_only: assert property (@(posedge pclk) disable iff (!presetn) // RL20
        (port_i.sense == smc_pkg::SMC_SENSE_FALL && $stable(port_i.sample))
        |-> !port_i.request)
        else $error("Edge mode requested without an edge");
endmodule

// File: hdl/smc_pwm_period.sv
`timescale 1ns/1ps

`include "smc_cfg.svh"

// Period counter of one modulator; slow select takes effect at once
module smc_pwm_period (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        timer_tick,
    input  wire logic        slow_sel,
    output logic [12:0]      phase,
    output logic             period_start
);
    logic [12:0] cnt_reg;
    logic [12:0] cnt_next;
    logic [12:0] last;

    // No double buffer: a change mid-period shortens or stretches it
    assign last = slow_sel ? (`SMC_PWM_SLOW_PER - 13'h0001)
                           : (`SMC_PWM_FAST_PER - 13'h0001); // RL9 RL10 RL12

    always_comb begin
        cnt_next = cnt_reg;
        if (timer_tick) begin
            if (cnt_reg >= last) begin
                cnt_next = 13'h0000;
            end else begin
                cnt_next = cnt_reg + 13'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 13'h0000;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign phase        = cnt_reg;
    assign period_start = timer_tick && (cnt_reg >= last);

    a_period_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RL9
        (timer_tick && !slow_sel && cnt_reg == 13'h00FF) |=> cnt_reg == 13'h0000)
        else $error("Fast period did not wrap at 256");

    a_slow_span: assert property (@(posedge pclk) disable iff (!presetn) // RL10
        (timer_tick && slow_sel && cnt_reg == 13'h00FF) |=> cnt_reg == 13'h0100)
        else $error("Slow period wrapped early");
endmodule

// File: hdl/smc_top.sv
// Overview of operation
// RL1: Power-on reset sets the power-on flag in bit 7.
// RL2: Software cannot set the flag; writing zero clears it, one keeps it.
// RL3: Select bits give pin sense: fall+low, fall, rise, both edges.
// RL4: Wired-OR port uses the inverted sense for the same select codes.
// RL5: Select bits are written only while the CPU interrupt mask is set.
// RL6: Power-on and external reset clear both select bits.
// RL7: Enable bit passes external pin requests; zero blocks them.
// RL8: Enable writable only under interrupt mask; reset sets it to one.
// RL9: Modulator A slow select picks 4096 timer periods, else 256.
// RL10: Modulator B slow select picks 4096 timer periods, else 256.
// RL11: Fastest rate is overflow rate times 256, slowest times 16.
// RL12: Software sets slow selects before modulator values; no buffering.
// RL13: Slow bus mode divides oscillator by 32, otherwise by 2.
// RL14: Reduced bus rate applies to every section of the device; here only the bus_clk_tick output is divided.
// RL15: Resets and entering stop mode clear the slow bus mode bit.
// RL16: Writing one to watchdog bit clears and enables the watchdog.
// RL17: Writing zero to watchdog bit has no effect.
// RL18: After any reset watchdog bit takes the build option value.
// RL19: Wired-OR request comes from port B inputs only while enabled.
// RL20: Pin sampled on bus clock; edges by compare, level holds request.
`timescale 1ns/1ps

`include "smc_cfg.svh"

module smc_top #(
    parameter logic WATCHDOG_ARM_OPTION = 1'b0
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        por_event,
    input  wire logic        ext_reset_event,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cpu_irq_mask,
    input  wire logic        stop_entry,
    input  wire logic        ext_irq_pin_n,
    input  wire logic [7:0]  port_b_pins,
    input  wire logic [7:0]  port_b_dir,
    input  wire logic        wired_or_irq_enable,
    input  wire logic        osc_tick,
    input  wire logic        timer_overflow_flag,
    output logic             ext_irq_request,
    output logic             bus_clk_tick,
    output logic             pwm_a_period_start,
    output logic             pwm_b_period_start,
    output logic [12:0]      pwm_a_phase,
    output logic [12:0]      pwm_b_phase,
    output logic             watchdog_enable,
    output logic             watchdog_clear
);
    logic       por_flag_reg;
    logic       por_flag_next;
    logic       ext_irq_rise_select_reg;
    logic       ext_irq_rise_select_next;
    logic       ext_irq_fall_select_reg;
    logic       ext_irq_fall_select_next;
    logic       ext_irq_enable_reg;
    logic       ext_irq_enable_next;
    logic       pwm_a_slow_select_reg;
    logic       pwm_a_slow_select_next;
    logic       pwm_b_slow_select_reg;
    logic       pwm_b_slow_select_next;
    logic       slow_bus_select_reg;
    logic       slow_bus_select_next;
    logic       watchdog_arm_reg;
    logic       watchdog_arm_next;
    logic       watchdog_arm_clear_reg;
    logic       watchdog_arm_clear_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic       pslverr_reg;
    logic       pslverr_next;
    logic [1:0] pin_sync_reg;
    logic [1:0] pin_sync_next;
    logic [7:0] pb_sync1_reg;
    logic [7:0] pb_sync2_reg;
    logic [5:0] div_reg;
    logic [5:0] div_next;
    logic       wr_hit;
    logic       wr_lane0;
    logic       addr_ok;
    logic [7:0] misc_view;
    logic [1:0] sense_sel;
    logic       ext_req;
    logic       woi_req;
    logic       woi_level;
    logic [5:0] div_last;

    smc_edge_if ext_if ();
    smc_edge_if woi_if ();

    assign addr_ok  = (paddr == `SMC_ADDR_MISC);
    assign wr_hit   = psel && penable && pwrite && addr_ok;
    assign wr_lane0 = wr_hit && pstrb[0];

    assign misc_view = {por_flag_reg, ext_irq_rise_select_reg, ext_irq_fall_select_reg,
                        ext_irq_enable_reg, pwm_a_slow_select_reg, pwm_b_slow_select_reg,
                        slow_bus_select_reg, watchdog_arm_reg};

    // Register fields; a hardware set always beats a software clear
    always_comb begin
        por_flag_next            = por_flag_reg;
        ext_irq_rise_select_next = ext_irq_rise_select_reg;
        ext_irq_fall_select_next = ext_irq_fall_select_reg;
        ext_irq_enable_next      = ext_irq_enable_reg;
        pwm_a_slow_select_next   = pwm_a_slow_select_reg;
        pwm_b_slow_select_next   = pwm_b_slow_select_reg;
        slow_bus_select_next     = slow_bus_select_reg;
        watchdog_arm_next        = watchdog_arm_reg;
        watchdog_arm_clear_next          = 1'b0;
        if (wr_lane0) begin
            if (!pwdata[`SMC_BIT_POR]) begin
                por_flag_next = 1'b0; // RL2
            end
            if (cpu_irq_mask) begin
                ext_irq_rise_select_next = pwdata[`SMC_BIT_RISE]; // RL5
                ext_irq_fall_select_next = pwdata[`SMC_BIT_FALL]; // RL5
                ext_irq_enable_next      = pwdata[`SMC_BIT_EXT_EN]; // RL8
            end
            pwm_a_slow_select_next = pwdata[`SMC_BIT_PWM_A];
            pwm_b_slow_select_next = pwdata[`SMC_BIT_PWM_B];
            slow_bus_select_next   = pwdata[`SMC_BIT_SLOW];
            if (pwdata[`SMC_BIT_WATCHDOG_ARM]) begin
                watchdog_arm_next = 1'b1; // RL16 RL17
                watchdog_arm_clear_next   = 1'b1; // RL16
            end
        end
        if (stop_entry) begin
            slow_bus_select_next = 1'b0; // RL15
        end
        if (ext_reset_event || por_event) begin
            ext_irq_rise_select_next = `SMC_RST_RISE; // RL6
            ext_irq_fall_select_next = `SMC_RST_FALL; // RL6
            ext_irq_enable_next      = `SMC_RST_EXT_EN; // RL8
            slow_bus_select_next     = `SMC_RST_SLOW; // RL15
            pwm_a_slow_select_next   = 1'b0;
            pwm_b_slow_select_next   = 1'b0;
            watchdog_arm_next        = WATCHDOG_ARM_OPTION; // RL18
            watchdog_arm_clear_next          = 1'b0;
        end
        if (por_event) begin
            por_flag_next = 1'b1; // RL1
        end
    end

    // Asynchronous reset is taken as power-on: flag set, watchdog at option
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_flag_reg            <= 1'b1; // RL1
            ext_irq_rise_select_reg <= `SMC_RST_RISE;
            ext_irq_fall_select_reg <= `SMC_RST_FALL;
            ext_irq_enable_reg      <= `SMC_RST_EXT_EN;
            pwm_a_slow_select_reg   <= 1'b0;
            pwm_b_slow_select_reg   <= 1'b0;
            slow_bus_select_reg     <= `SMC_RST_SLOW;
            watchdog_arm_reg        <= WATCHDOG_ARM_OPTION; // RL18
            watchdog_arm_clear_reg          <= 1'b0;
        end else begin
            por_flag_reg            <= por_flag_next;
            ext_irq_rise_select_reg <= ext_irq_rise_select_next;
            ext_irq_fall_select_reg <= ext_irq_fall_select_next;
            ext_irq_enable_reg      <= ext_irq_enable_next;
            pwm_a_slow_select_reg   <= pwm_a_slow_select_next;
            pwm_b_slow_select_reg   <= pwm_b_slow_select_next;
            slow_bus_select_reg     <= slow_bus_select_next;
            watchdog_arm_reg        <= watchdog_arm_next;
            watchdog_arm_clear_reg          <= watchdog_arm_clear_next;
        end
    end

    assign watchdog_enable = watchdog_arm_reg;
    assign watchdog_clear  = watchdog_arm_clear_reg;

    // APB slave: zero wait states, read data registered in setup
    always_comb begin
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        if (psel && !penable) begin
            prdata_next  = addr_ok ? {24'h00_0000, misc_view} : 32'h0000_0000;
            pslverr_next = !addr_ok;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = pslverr_reg && psel && penable;

    // Pins come from outside the clock domain
    always_comb begin
        pin_sync_next = {pin_sync_reg[0], ext_irq_pin_n};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync_reg <= 2'b11;
            pb_sync1_reg <= 8'h00;
            pb_sync2_reg <= 8'h00;
        end else begin
            pin_sync_reg <= pin_sync_next;
            pb_sync1_reg <= port_b_pins;
            pb_sync2_reg <= pb_sync1_reg;
        end
    end

    assign sense_sel = {ext_irq_rise_select_reg, ext_irq_fall_select_reg};

    assign ext_if.sample = pin_sync_reg[1];
    assign ext_if.sense  = smc_pkg::smc_sense_e'(sense_sel); // RL3

    // Inverting the wired-OR level gives the mirrored sensitivity
    assign woi_level     = ~(|(pb_sync2_reg & ~port_b_dir)); // RL19 RL4
    assign woi_if.sample = woi_level;
    assign woi_if.sense  = smc_pkg::smc_sense_e'(sense_sel); // RL4

    smc_edge_detect u_ext_det (
        .pclk    (pclk),
        .presetn (presetn),
        .port_i  (ext_if.detector)
    );

    smc_edge_detect u_woi_det (
        .pclk    (pclk),
        .presetn (presetn),
        .port_i  (woi_if.detector)
    );

    assign ext_req = ext_if.request & ext_irq_enable_reg; // RL7
    assign woi_req = woi_if.request & wired_or_irq_enable; // RL19
    assign ext_irq_request = ext_req | woi_req;

    // Bus tick divider; the tick only drives the bus_clk_tick output, no section here uses it
    assign div_last = slow_bus_select_reg ? (`SMC_DIV_SLOW - 6'h01)
                                          : (`SMC_DIV_NORMAL - 6'h01); // RL13

    always_comb begin
        div_next = div_reg;
        if (osc_tick) begin
            div_next = (div_reg >= div_last) ? 6'h00 : div_reg + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 6'h00;
        end else begin
            div_reg <= div_next;
        end
    end

    assign bus_clk_tick = osc_tick && (div_reg >= div_last); // RL14

    // Period 256 or 4096 timer clocks gives overflow rate x256 or x16
    smc_pwm_period u_pwm_a (
        .pclk         (pclk),
        .presetn      (presetn),
        .timer_tick   (timer_overflow_flag),
        .slow_sel     (pwm_a_slow_select_reg),
        .phase        (pwm_a_phase),
        .period_start (pwm_a_period_start)
    ); // RL9 RL11

    smc_pwm_period u_pwm_b (
        .pclk         (pclk),
        .presetn      (presetn),
        .timer_tick   (timer_overflow_flag),
        .slow_sel     (pwm_b_slow_select_reg),
        .phase        (pwm_b_phase),
        .period_start (pwm_b_period_start)
    ); // RL10 RL11

    a_por_sets: assert property (@(posedge pclk) disable iff (!presetn) // RL1
        por_event |=> por_flag_reg)
        else $error("Power-on did not set the flag");

    a_por_no_swset: assert property (@(posedge pclk) disable iff (!presetn) // RL2
        (!por_flag_reg && !por_event) |=> !por_flag_reg)
        else $error("Power-on flag set without power-on");

    a_mask_guard: assert property (@(posedge pclk) disable iff (!presetn) // RL5
        (wr_lane0 && !cpu_irq_mask && !por_event && !ext_reset_event)
        |=> $stable(sense_sel) && $stable(ext_irq_enable_reg))
        else $error("Select or enable changed without mask");

    a_reset_sense: assert property (@(posedge pclk) disable iff (!presetn) // RL6
        ext_reset_event |=> sense_sel == 2'b00 && ext_irq_enable_reg)
        else $error("External reset left sense or enable wrong");

    a_ext_block: assert property (@(posedge pclk) disable iff (!presetn) // RL7
        !ext_irq_enable_reg && !woi_req |-> !ext_irq_request)
        else $error("Blocked request passed");

    a_watchdog_arm_arm: assert property (@(posedge pclk) disable iff (!presetn) // RL16
        (wr_lane0 && pwdata[`SMC_BIT_WATCHDOG_ARM] && !por_event && !ext_reset_event)
        |=> watchdog_arm_reg && watchdog_clear)
        else $error("Watchdog write one did not arm");

    a_watchdog_arm_stay: assert property (@(posedge pclk) disable iff (!presetn) // RL17
        (watchdog_arm_reg && !por_event && !ext_reset_event) |=> watchdog_arm_reg)
        else $error("Watchdog became disabled");

    a_stop_slow: assert property (@(posedge pclk) disable iff (!presetn) // RL15
        stop_entry |=> !slow_bus_select_reg)
        else $error("Stop entry left slow mode set");

    a_slow_div: assert property (@(posedge pclk) disable iff (!presetn) // RL13
        (slow_bus_select_reg && bus_clk_tick) |-> div_reg == 6'h1F)
        else $error("Slow mode divide is not 32");
endmodule

// File: verif/test_system_misc_control.sv
`timescale 1ns/1ps

module test_system_misc_control;
    localparam logic W = 1'b0;
    logic        pclk, presetn, por_event, ext_reset_event, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        pready, pslverr, cpu_irq_mask, stop_entry, ext_irq_pin_n;
    logic [7:0]  port_b_pins, port_b_dir, m;
    logic        wired_or_irq_enable, osc_tick, timer_overflow_flag, ext_irq_request;
    logic        bus_clk_tick, pwm_a_period_start, pwm_b_period_start;
    logic [12:0] pwm_a_phase, pwm_b_phase;
    logic        watchdog_enable, watchdog_clear;
    int          err_count, check_count, seed, i;
    logic [31:0] r;
    logic        e;

    smc_top #(.WATCHDOG_ARM_OPTION(W)) i_dut (.pclk(pclk), .presetn(presetn), .por_event(por_event),
        .ext_reset_event(ext_reset_event), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_irq_mask(cpu_irq_mask), .stop_entry(stop_entry),
        .ext_irq_pin_n(ext_irq_pin_n), .port_b_pins(port_b_pins), .port_b_dir(port_b_dir),
        .wired_or_irq_enable(wired_or_irq_enable), .osc_tick(osc_tick),
        .timer_overflow_flag(timer_overflow_flag), .ext_irq_request(ext_irq_request),
        .bus_clk_tick(bus_clk_tick), .pwm_a_period_start(pwm_a_period_start),
        .pwm_b_period_start(pwm_b_period_start), .pwm_a_phase(pwm_a_phase),
        .pwm_b_phase(pwm_b_phase), .watchdog_enable(watchdog_enable),
        .watchdog_clear(watchdog_clear));

    always #5 pclk = ~pclk;

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
            err_count++;
        end
    endtask

    task automatic timeout();
        $display("CHECK FAILED at %0t: wait limit reached", $time);
        err_count++;
        give_verdict();
    endtask

    // Answer is taken at the edge that sees pready high, before that edge updates it
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic er);
        int   n;
        logic rdy;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
            rdy = pready;
        end while (rdy !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (rdy !== 1'b1) timeout();
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk();
        logic [31:0] rd;
        logic        er;
        apb(1'b0, 12'h00c, 8'h00, 4'h0, rd, er);
        check(rd, {24'h00_0000, m});
        check(er, 0);
        check(watchdog_enable, m[0]);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic msk,
                      input logic [3:0] s);
        logic [31:0] rd;
        logic        er;
        int          c;
        @(posedge pclk);
        cpu_irq_mask <= msk;
        apb(1'b1, a, d, s, rd, er);
        check(er, a != 12'h00c);
        c = 0;
        repeat (4) begin
            @(negedge pclk);
            if (watchdog_clear === 1'b1) c++;
        end
        check(c, a == 12'h00c && s[0] && d[0]);
        if (a == 12'h00c && s[0]) begin
            if (!d[7]) m[7] = 1'b0;
            if (msk) m[6:4] = d[6:4];
            m[3:1] = d[3:1];
            if (d[0]) m[0] = 1'b1;
        end
    endtask

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        m = {4'h9, 3'b000, W};
    endtask

    task automatic evt(input int k);
        @(posedge pclk);
        if (k == 0) por_event <= 1'b1;
        if (k == 1) ext_reset_event <= 1'b1;
        if (k == 2) stop_entry <= 1'b1;
        @(posedge pclk);
        por_event       <= 1'b0;
        ext_reset_event <= 1'b0;
        stop_entry      <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    function automatic logic pick(input int k);
        return k == 0 ? pwm_a_period_start : (k == 1 ? pwm_b_period_start : bus_clk_tick);
    endfunction

    // Third gap is measured so a mode switch mid-count cannot skew it
    task automatic gap(input int k, input int exp);
        int n;
        repeat (3) begin
            n = 0;
            do begin
                @(negedge pclk);
                n++;
            end while (pick(k) !== 1'b1 && n < 5000);
            if (n >= 5000) timeout();
        end
        check(n, exp);
        if (k < 2) check(k == 0 ? pwm_a_phase : pwm_b_phase, exp - 1);
    endtask

    task automatic sense(input logic [1:0] md, input logic en, input logic wo,
                         input logic [7:0] dir, input logic p0, input logic p1,
                         input logic [7:0] b0, input logic [7:0] b1, input logic exp);
        logic seen;
        wr(12'h00c, {1'b1, md, en, m[3:1], 1'b0}, 1'b1, 4'h1);
        @(posedge pclk);
        wired_or_irq_enable <= wo;
        port_b_dir          <= dir;
        ext_irq_pin_n       <= p0;
        port_b_pins         <= b0;
        repeat (10) @(posedge pclk);
        ext_irq_pin_n <= p1;
        port_b_pins   <= b1;
        seen = 1'b0;
        repeat (8) begin
            @(negedge pclk);
            if (ext_irq_request === 1'b1) seen = 1'b1;
        end
        check(seen, exp);
    endtask

    initial begin
        {pclk, por_event, ext_reset_event, psel, penable, pwrite, stop_entry} = '0;
        {paddr, pwdata, pstrb, cpu_irq_mask, port_b_pins, port_b_dir} = '0;
        {wired_or_irq_enable, err_count, check_count} = '0;
        {presetn, ext_irq_pin_n, osc_tick, timer_overflow_flag} = 4'h7;
        seed = 57883;
        do_reset();
        rd_chk();
        wr(12'h00c, 8'h00, 1'b0, 4'h1);
        rd_chk();
        wr(12'h00c, 8'hFF, 1'b0, 4'hF);
        rd_chk();
        wr(12'h00c, 8'hFF, 1'b1, 4'h1);
        rd_chk();
        wr(12'h00c, 8'h00, 1'b1, 4'hE);
        rd_chk();
        apb(1'b0, 12'h010, 8'h00, 4'h0, r, e);
        check(r, 0);
        check(e, 1);
        wr(12'h010, 8'h00, 1'b1, 4'hF);
        rd_chk();
        for (i = 0; i < 16; i++) begin
            r = $random(seed);
            wr(r[31] ? 12'h004 : 12'h00c, r[7:0], r[8], r[12:9]);
            rd_chk();
        end
        wr(12'h00c, {m[7:2], 1'b0, m[0]}, 1'b1, 4'h1);
        gap(2, 2);
        wr(12'h00c, {m[7:2], 1'b1, m[0]}, 1'b1, 4'h1);
        gap(2, 32);
        evt(2);
        m[1] = 1'b0;
        rd_chk();
        wr(12'h00c, {m[7:4], 2'b01, m[1:0]}, 1'b0, 4'h1);
        gap(0, 256);
        gap(1, 4096);
        wr(12'h00c, {m[7:4], 2'b10, m[1:0]}, 1'b0, 4'h1);
        gap(0, 4096);
        gap(1, 256);
        sense(2'b00, 1, 0, 8'h00, 1, 0, 8'h00, 8'h00, 1);
        sense(2'b00, 1, 0, 8'h00, 0, 0, 8'h00, 8'h00, 1);
        sense(2'b01, 1, 0, 8'h00, 1, 0, 8'h00, 8'h00, 1);
        sense(2'b01, 1, 0, 8'h00, 0, 1, 8'h00, 8'h00, 0);
        sense(2'b10, 1, 0, 8'h00, 0, 1, 8'h00, 8'h00, 1);
        sense(2'b10, 1, 0, 8'h00, 1, 0, 8'h00, 8'h00, 0);
        sense(2'b11, 1, 0, 8'h00, 0, 1, 8'h00, 8'h00, 1);
        sense(2'b11, 1, 0, 8'h00, 1, 0, 8'h00, 8'h00, 1);
        sense(2'b00, 0, 0, 8'h00, 1, 0, 8'h00, 8'h00, 0);
        sense(2'b00, 1, 1, 8'h00, 1, 1, 8'h00, 8'h10, 1);
        sense(2'b00, 1, 1, 8'h00, 1, 1, 8'h10, 8'h10, 1);
        sense(2'b01, 1, 1, 8'h00, 1, 1, 8'h10, 8'h00, 0);
        sense(2'b01, 1, 1, 8'h00, 1, 1, 8'h00, 8'h10, 1);
        sense(2'b10, 1, 1, 8'h00, 1, 1, 8'h10, 8'h00, 1);
        sense(2'b10, 1, 1, 8'h00, 1, 1, 8'h00, 8'h10, 0);
        sense(2'b11, 1, 1, 8'h00, 1, 1, 8'h10, 8'h00, 1);
        sense(2'b00, 1, 1, 8'h10, 1, 1, 8'h00, 8'h10, 0);
        sense(2'b00, 1, 0, 8'h00, 1, 1, 8'h00, 8'h10, 0);
        wr(12'h00c, 8'h7F, 1'b1, 4'h1);
        evt(1);
        m = {m[7], 3'b001, 3'b000, W};
        rd_chk();
        evt(0);
        m = {4'h9, 3'b000, W};
        rd_chk();
        wr(12'h00c, 8'h7F, 1'b1, 4'h1);
        do_reset();
        rd_chk();
        give_verdict();
    end
endmodule
